// [hdl/slep_programmer.sv]
/*
 Supply-line programmer of the 16 x 16 configuration array: qualifies entry,
 decodes supply symbols into commands, writes, reads out and reads back the
 converters. Assumes comparator outputs and the address pin sense are
 asynchronous, converter results and the refresh tick come from core_clk.
*/
//
// Behaviour
// RL1 - configuration held in a user-writable array of sixteen 16-bit words
// RL2 - station raises supply to programming level; device enters programming mode
// RL3 - entry only after supply above 10V continuously longer than 25 us
// RL4 - station starts clocking between 4 ms and 10 ms after power-on
// RL5 - 16V means one, 10V means zero, 13V between bits
// RL6 - station holds each level between 20 us and 110 us
// RL7 - command: five opcode bits, two select bits, five opcode bits mirrored
// RL8 - four commands recognised plus an unlock code
// RL9 - every other command pattern is ignored
// RL10 - decode the two write patterns, both pins or digital pin only
// RL11 - write and read-out carry 256 array bits then 20-bit checksum
// RL12 - payload runs from LSB of first word to MSB of last word
// RL13 - checksum mismatch leaves the array untouched
// RL14 - decode the read-out pattern, shift words and checksum out
// RL15 - converter read needs unlock, supply drop, 21 refresh waits, 36 clocks
// RL16 - each read-out clock advances one bit; extra clock drives outputs low
// RL17 - act only when select bits match the address pin level, 00 or 11; unlock and converter codes are taken with 00 whatever the pin level
// RL18 - checksum is the 20-bit truncated unsigned sum of the sixteen words
`timescale 1ns/10ps
`include "slep_cfg.svh"

module slep_programmer #(
    parameter int unsigned ENTRY_CYCLES = `SLEP_ENTRY_US * `SLEP_CLK_MHZ + 1
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic supAboveTen,
    input wire logic supOneLevel,
    input wire logic supProgLevel,
    input wire logic supZeroLevel,
    input wire logic aoutSense,
    input wire logic refreshTick,
    input wire logic [12:0] adcResult1,
    input wire logic [12:0] adcResult2,
    input wire logic [9:0] adcResult10,
    input wire logic [3:0] cfgRdAddr,
    output logic [15:0] cfgRdData,
    output logic progMode,
    output logic aoutOut,
    output logic aoutOe,
    output logic doutOut,
    output logic doutOe
);
    import slep_pkg::*;

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic [4:0] syncA_r;
    logic [4:0] syncB_r;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            syncA_r <= '0;
            syncB_r <= '0;
        end
        else
        begin
            syncA_r <= {aoutSense, supAboveTen, supOneLevel, supProgLevel, supZeroLevel};
            syncB_r <= syncA_r;
        end
    end

    // ------------------------------------------------------------------
    // level class and symbol strobe
    // ------------------------------------------------------------------
    slep_level_type lvl;
    slep_level_type lvlPrev_r;
    logic sym;
    logic symBit;

    always_comb
    begin
        if (syncB_r[2])
            lvl = LVL_HIGH;
        else if (syncB_r[1])
            lvl = LVL_PROG;
        else if (syncB_r[0])
            lvl = LVL_LOW;
        else
            lvl = LVL_OFF;
    end

    // a bit counts only on leaving the 13V level, so it is taken once
    assign sym = (lvlPrev_r == LVL_PROG) && (lvl == LVL_HIGH || lvl == LVL_LOW); // see RL5
    assign symBit = (lvl == LVL_HIGH); // see RL5

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    function automatic slep_cmd_type decodeCmd(input logic [11:0] c, input logic sense);
        logic [11:0] op;
        logic [1:0] cs;
        logic csOk;
        op = c & ~`SLEP_CS_MASK;
        cs = c[`SLEP_CS_LSB +: 2];
        csOk = (cs == 2'b00 && !sense) || (cs == 2'b11 && sense); // see RL17
        if (c == `SLEP_CMD_UNLOCK)
            decodeCmd = CMD_UNLOCK; // see RL8
        else if (c == `SLEP_CMD_ADC)
            decodeCmd = CMD_ADC; // see RL8
        else if (op == `SLEP_CMD_WR_BOTH && csOk)
            decodeCmd = CMD_WR_BOTH; // see RL10
        else if (op == `SLEP_CMD_WR_DOUT && csOk)
            decodeCmd = CMD_WR_DOUT; // see RL10
        else if (op == `SLEP_CMD_READ && csOk)
            decodeCmd = CMD_READ; // see RL14
        else
            decodeCmd = CMD_NONE; // see RL9
    endfunction

    // ------------------------------------------------------------------
    // memories: staging for incoming words, the nonvolatile array
    // ------------------------------------------------------------------
    slep_mem_if #(.AW(4), .DW(`SLEP_WORD_BITS)) stg();
    slep_mem_if #(.AW(4), .DW(`SLEP_WORD_BITS)) nvm();

    slep_mem #(.DEPTH(`SLEP_WORDS), .DW(`SLEP_WORD_BITS)) stageMem (
        .core_clk(core_clk),
        .resetn(resetn),
        .port(stg.mem)
    );

    slep_mem #(.DEPTH(`SLEP_WORDS), .DW(`SLEP_WORD_BITS)) nvArray ( // see RL1
        .core_clk(core_clk),
        .resetn(resetn),
        .port(nvm.mem)
    );

    // ------------------------------------------------------------------
    // controller
    // ------------------------------------------------------------------
    slep_state_type state_r, state_nxt;
    logic [15:0] entryCnt_r, entryCnt_nxt;
    logic [19:0] shift_r, shift_nxt;
    logic [8:0] bitCnt_r, bitCnt_nxt;
    logic [19:0] sum_r, sum_nxt;
    logic [4:0] wordIdx_r, wordIdx_nxt;
    logic [4:0] refCnt_r, refCnt_nxt;
    logic [35:0] adcShift_r, adcShift_nxt;
    logic unlock_r, unlock_nxt;
    logic wrBoth_r, wrBoth_nxt;
    logic analog_output_pin_r, analog_output_pin_nxt, aoutOe_r, aoutOe_nxt;
    logic dout_r, dout_nxt, doutOe_r, doutOe_nxt;
    logic [15:0] newWord;
    logic [19:0] newSum;
    logic [11:0] newCmd;
    logic [4:0] sumIdx;
    logic readBit;

    assign newWord = {symBit, shift_r[15:1]}; // see RL12
    assign newSum = {symBit, shift_r[19:1]};
    assign newCmd = {shift_r[10:0], symBit}; // see RL7
    assign sumIdx = 5'(bitCnt_r - `SLEP_PAYLOAD_BITS);

    always_comb
    begin
        if (bitCnt_r < `SLEP_PAYLOAD_BITS)
            readBit = nvm.rdata[bitCnt_r[3:0]];
        else if (bitCnt_r <= `SLEP_READ_LAST)
            readBit = sum_r[sumIdx];
        else
            readBit = 1'b0; // see RL16
    end

    always_comb
    begin
        state_nxt = state_r;
        entryCnt_nxt = entryCnt_r;
        shift_nxt = shift_r;
        bitCnt_nxt = bitCnt_r;
        sum_nxt = sum_r;
        wordIdx_nxt = wordIdx_r;
        refCnt_nxt = refCnt_r;
        adcShift_nxt = adcShift_r;
        unlock_nxt = unlock_r;
        wrBoth_nxt = wrBoth_r;
        analog_output_pin_nxt = analog_output_pin_r;
        aoutOe_nxt = aoutOe_r;
        dout_nxt = dout_r;
        doutOe_nxt = doutOe_r;
        stg.we = 1'b0;
        stg.waddr = bitCnt_r[7:4];
        stg.wdata = newWord;
        stg.raddr = wordIdx_r[3:0];
        nvm.we = 1'b0;
        nvm.waddr = 4'(wordIdx_r - 5'h01);
        nvm.wdata = stg.rdata;
        nvm.raddr = cfgRdAddr;
        unique case (state_r)
            ST_IDLE:
            begin
                // any dip below 10V restarts the qualification
                if (!syncB_r[3])
                    entryCnt_nxt = '0; // see RL3
                else if (entryCnt_r >= ENTRY_CYCLES[15:0])
                begin
                    state_nxt = ST_CMD; // see RL2
                    bitCnt_nxt = '0;
                    unlock_nxt = 1'b0;
                end
                else
                    entryCnt_nxt = entryCnt_r + 16'h0001; // see RL3
            end
            ST_CMD:
            begin
                if (sym)
                begin
                    shift_nxt = {8'h00, newCmd};
                    bitCnt_nxt = bitCnt_r + 9'h001;
                    if (bitCnt_r == `SLEP_CMD_LAST)
                    begin
                        bitCnt_nxt = '0;
                        sum_nxt = '0;
                        wordIdx_nxt = '0;
                        unlock_nxt = 1'b0;
                        unique case (decodeCmd(newCmd, syncB_r[4]))
                            CMD_WR_BOTH, CMD_WR_DOUT:
                            begin
                                state_nxt = ST_WR_DATA;
                                wrBoth_nxt = (decodeCmd(newCmd, syncB_r[4]) == CMD_WR_BOTH);
                            end
                            CMD_READ:
                                state_nxt = ST_RD_SUM;
                            CMD_ADC:
                            begin
                                if (unlock_r)
                                    state_nxt = ST_ADC_DROP; // see RL15
                            end
                            CMD_UNLOCK:
                                unlock_nxt = 1'b1; // see RL15
                            CMD_NONE:
                                state_nxt = ST_CMD; // see RL9
                        endcase
                    end
                end
            end
            ST_WR_DATA:
            begin
                if (sym)
                begin
                    shift_nxt = {4'h0, newWord};
                    bitCnt_nxt = bitCnt_r + 9'h001;
                    if (bitCnt_r[3:0] == 4'hF)
                    begin
                        stg.we = 1'b1;
                        sum_nxt = sum_r + {4'h0, newWord}; // see RL18
                    end
                    if (bitCnt_r == `SLEP_PAYLOAD_BITS - 9'h001)
                    begin
                        state_nxt = ST_WR_SUM; // see RL11
                        bitCnt_nxt = '0;
                    end
                end
            end
            ST_WR_SUM:
            begin
                if (sym)
                begin
                    shift_nxt = newSum;
                    bitCnt_nxt = bitCnt_r + 9'h001;
                    if (bitCnt_r == 9'(`SLEP_SUM_BITS - 1))
                    begin
                        state_nxt = (newSum == sum_r) ? ST_WR_COPY : ST_WR_DONE; // see RL13
                        dout_nxt = 1'b0;
                    end
                end
            end
            ST_WR_COPY:
            begin
                // never abandoned halfway, a partial copy would corrupt the array
                nvm.we = (wordIdx_r != 5'h00);
                wordIdx_nxt = wordIdx_r + 5'h01;
                if (wordIdx_r == 5'(`SLEP_WORDS))
                begin
                    state_nxt = ST_WR_DONE;
                    // digital value and drive rise together, never a one on the released digital pin
                    dout_nxt = 1'b1;
                    doutOe_nxt = 1'b1;
                end
            end
            ST_WR_DONE:
            begin
                doutOe_nxt = 1'b1;
                aoutOe_nxt = wrBoth_r;
                analog_output_pin_nxt = dout_r;
            end
            ST_RD_SUM:
            begin
                nvm.raddr = wordIdx_r[3:0];
                wordIdx_nxt = wordIdx_r + 5'h01;
                if (wordIdx_r != 5'h00)
                    sum_nxt = sum_r + {4'h0, nvm.rdata}; // see RL18
                if (wordIdx_r == 5'(`SLEP_WORDS))
                begin
                    state_nxt = ST_RD_OUT;
                    analog_output_pin_nxt = 1'b1;
                    dout_nxt = 1'b1;
                    aoutOe_nxt = 1'b1;
                    doutOe_nxt = 1'b1;
                end
            end
            ST_RD_OUT:
            begin
                nvm.raddr = bitCnt_r[7:4]; // see RL12
                if (sym)
                begin
                    analog_output_pin_nxt = readBit; // see RL16
                    dout_nxt = readBit; // see RL14
                    if (bitCnt_r != `SLEP_READ_END)
                        bitCnt_nxt = bitCnt_r + 9'h001;
                end
            end
            ST_ADC_DROP:
            begin
                refCnt_nxt = '0;
                if (lvl == LVL_OFF)
                    state_nxt = ST_ADC_WAIT; // see RL15
            end
            ST_ADC_WAIT:
            begin
                if (refreshTick)
                    refCnt_nxt = refCnt_r + 5'h01;
                if (refCnt_r == `SLEP_REFRESH_WAIT)
                begin
                    adcShift_nxt = {adcResult10, adcResult2, adcResult1}; // see RL15
                    state_nxt = ST_ADC_RISE;
                end
            end
            ST_ADC_RISE:
            begin
                if (lvl == LVL_PROG)
                begin
                    state_nxt = ST_ADC_OUT;
                    bitCnt_nxt = '0;
                    analog_output_pin_nxt = 1'b1;
                    dout_nxt = 1'b1;
                    aoutOe_nxt = 1'b1;
                    doutOe_nxt = 1'b1;
                end
            end
            ST_ADC_OUT:
            begin
                if (sym)
                begin
                    bitCnt_nxt = bitCnt_r + 9'h001;
                    analog_output_pin_nxt = adcShift_r[0];
                    dout_nxt = adcShift_r[0];
                    adcShift_nxt = {1'b0, adcShift_r[35:1]};
                    if (bitCnt_r == `SLEP_ADC_LAST)
                    begin
                        state_nxt = ST_CMD; // see RL15
                        bitCnt_nxt = '0;
                        analog_output_pin_nxt = 1'b0;
                        dout_nxt = 1'b0;
                        aoutOe_nxt = 1'b0;
                        doutOe_nxt = 1'b0;
                    end
                end
            end
        endcase
        // supply gone: leave the mode, except during the array copy and where the drop is expected
        if (lvl == LVL_OFF && state_r != ST_IDLE && state_r != ST_WR_COPY &&
            state_r != ST_ADC_DROP && state_r != ST_ADC_WAIT && state_r != ST_ADC_RISE)
        begin
            state_nxt = ST_IDLE;
            entryCnt_nxt = '0;
            analog_output_pin_nxt = 1'b0;
            dout_nxt = 1'b0;
            aoutOe_nxt = 1'b0;
            doutOe_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= ST_IDLE;
            lvlPrev_r <= LVL_OFF;
            entryCnt_r <= '0;
            shift_r <= '0;
            bitCnt_r <= '0;
            sum_r <= '0;
            wordIdx_r <= '0;
            refCnt_r <= '0;
            adcShift_r <= '0;
            unlock_r <= 1'b0;
            wrBoth_r <= 1'b0;
            analog_output_pin_r <= 1'b0;
            aoutOe_r <= 1'b0;
            dout_r <= 1'b0;
            doutOe_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            lvlPrev_r <= lvl;
            entryCnt_r <= entryCnt_nxt;
            shift_r <= shift_nxt;
            bitCnt_r <= bitCnt_nxt;
            sum_r <= sum_nxt;
            wordIdx_r <= wordIdx_nxt;
            refCnt_r <= refCnt_nxt;
            adcShift_r <= adcShift_nxt;
            unlock_r <= unlock_nxt;
            wrBoth_r <= wrBoth_nxt;
            analog_output_pin_r <= analog_output_pin_nxt;
            aoutOe_r <= aoutOe_nxt;
            dout_r <= dout_nxt;
            doutOe_r <= doutOe_nxt;
        end
    end

    assign progMode = (state_r != ST_IDLE);
    assign cfgRdData = nvm.rdata;
    assign aoutOut = analog_output_pin_r;
    assign aoutOe = aoutOe_r;
    assign doutOut = dout_r;
    assign doutOe = doutOe_r;
endmodule

// [hdl/slep_cfg.svh]
/*
 Constants of the supply-line programmer: offsets of command fields, codes,
 payload sizes and timing figures. Assumes a single 200 MHz core clock.
*/
`ifndef SLEP_CFG_SVH
`define SLEP_CFG_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define SLEP_CLK_MHZ 200
`define SLEP_ENTRY_US 25
`define SLEP_REFRESH_WAIT 5'h15

// ----------------------------------------------------------------------
// array and payload
// ----------------------------------------------------------------------
`define SLEP_WORDS 16
`define SLEP_WORD_BITS 16
`define SLEP_SUM_BITS 20
`define SLEP_PAYLOAD_BITS 9'h100
`define SLEP_READ_LAST 9'h113
`define SLEP_READ_END 9'h115

// ----------------------------------------------------------------------
// commands, first sent bit is bit 11
// ----------------------------------------------------------------------
`define SLEP_CMD_BITS 12
`define SLEP_CMD_LAST 9'h00B
`define SLEP_CS_LSB 5
`define SLEP_CS_MASK 12'h060
`define SLEP_CMD_WR_BOTH 12'h801
`define SLEP_CMD_WR_DOUT 12'h402
`define SLEP_CMD_READ 12'hA05
`define SLEP_CMD_ADC 12'h090
`define SLEP_CMD_UNLOCK 12'h59A

// ----------------------------------------------------------------------
// converter read-back
// ----------------------------------------------------------------------
`define SLEP_ADC_BITS 36
`define SLEP_ADC_LAST 9'h024

`endif

// [hdl/slep_pkg.sv]
/*
 Types of the supply-line programmer: supply level classes, controller states
 and decoded commands. Assumes the constants header is included by users.
*/
package slep_pkg;

    typedef enum logic [1:0] {LVL_OFF, LVL_LOW, LVL_PROG, LVL_HIGH} slep_level_type;

    typedef enum logic [3:0] {
        ST_IDLE, ST_CMD, ST_WR_DATA, ST_WR_SUM, ST_WR_COPY, ST_WR_DONE,
        ST_RD_SUM, ST_RD_OUT, ST_ADC_DROP, ST_ADC_WAIT, ST_ADC_RISE, ST_ADC_OUT
    } slep_state_type;

    typedef enum logic [2:0] {
        CMD_NONE, CMD_WR_BOTH, CMD_WR_DOUT, CMD_READ, CMD_ADC, CMD_UNLOCK
    } slep_cmd_type;

endpackage

// [hdl/slep_mem_if.sv]
/*
 Carrier between the programmer and its word memories: one write port and
 one read port whose data come out of a register one cycle later.
*/
`timescale 1ns/10ps

interface slep_mem_if #(parameter int AW = 4, parameter int DW = 16);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;

    modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// [hdl/slep_mem.sv]
/*
 Small word memory with registered read data. Assumes one clock; the array
 itself has no reset, only the read register does.
*/
`timescale 1ns/10ps

module slep_mem #(
    parameter int DEPTH = 16,
    parameter int DW = 16
) (
    input wire logic core_clk,
    input wire logic resetn,
    slep_mem_if.mem port
);
    logic [DW-1:0] array [DEPTH];
    logic [DW-1:0] rdata_r;

    always_ff @(posedge core_clk)
    begin
        if (port.we)
        begin
            array[port.waddr] <= port.wdata;
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_r <= '0;
        end
        else
        begin
            rdata_r <= array[port.raddr];
        end
    end

    assign port.rdata = rdata_r;
endmodule

// [test/slep_station.sv]
/*
 Programming station model: sets the supply level seen by the four level
 comparators. Assumes tasks are entered just after a rising clock edge.
*/
`timescale 1ns/10ps

module slep_station (
    input wire logic core_clk,
    output logic supAboveTen,
    output logic supOneLevel,
    output logic supProgLevel,
    output logic supZeroLevel
);
    import slep_pkg::*;
    slep_level_type lvl = LVL_OFF;
    // ----------------
    // comparator view
    // ----------------
    assign supAboveTen = (lvl != LVL_OFF);
    assign supOneLevel = (lvl == LVL_HIGH);
    assign supProgLevel = (lvl == LVL_PROG);
    assign supZeroLevel = (lvl == LVL_LOW);

    task automatic hold(slep_level_type l, int n);
        lvl = l;
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // 4 cycles a level stands in for the scaled hold window
    task automatic sym(logic b);
        hold(b ? LVL_HIGH : LVL_LOW, 4);
        hold(LVL_PROG, 4);
    endtask
endmodule

// [test/slep_programmer_assertions.sv]
/*
 Checker of the programmer's top ports, bound to every instance.
 Assumes one clock domain and an active-low asynchronous reset.
*/
`timescale 1ns/10ps

module slep_programmer_assertions #(
    parameter int unsigned ENTRY_CYCLES = 5001
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic supAboveTen,
    input wire logic [3:0] cfgRdAddr,
    input wire logic [15:0] cfgRdData,
    input wire logic progMode,
    input wire logic aoutOut,
    input wire logic aoutOe,
    input wire logic doutOut,
    input wire logic doutOe
);
    // ----------------
    // raw run of supply above threshold
    // ----------------
    int unsigned highRun_r;
    int unsigned highRun_nxt;
    always_comb
    begin
        highRun_nxt = highRun_r;
        if (!supAboveTen)
            highRun_nxt = 0;
        else if (highRun_r < ENTRY_CYCLES)
            highRun_nxt = highRun_r + 1;
    end
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            highRun_r <= 0;
        else
            highRun_r <= highRun_nxt;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);

    AST_ENTRY_QUALIFIED: assert property ($rose(progMode) |-> highRun_r >= ENTRY_CYCLES)
        else $error("programming mode entered too early");
    AST_QUIET_AFTER_RESET: assert property ($rose(resetn) |-> !progMode && !doutOe && !aoutOe)
        else $error("outputs active right after reset");
    AST_PINS_NEED_MODE: assert property ((!progMode && !$past(progMode)) |-> !doutOe && !aoutOe)
        else $error("pin driven outside programming mode");
    AST_PINS_AGREE: assert property (aoutOe |-> doutOe && aoutOut == doutOut)
        else $error("analog pin differs from digital pin");
    AST_ONE_NEEDS_DRIVE: assert property (doutOut |-> doutOe)
        else $error("digital value set while released");
    AST_NO_EARLY_DRIVE: assert property ($rose(progMode) |-> !doutOe [*8])
        else $error("pin driven before any command");
    AST_OFF_RELEASES: assert property ((doutOe && !supAboveTen) [*4] |-> ##[0:3] !doutOe)
        else $error("pin still driven after supply dropped");
    AST_ARRAY_STEADY: assert property (
        ($stable(cfgRdAddr) && !progMode && !$past(progMode) && $past(resetn))
        |=> $stable(cfgRdData))
        else $error("array content changed outside programming");

    COV_ENTRY: cover property ($rose(progMode));
    COV_BOTH_PINS: cover property ($rose(aoutOe));
    COV_DIGITAL_ONLY: cover property (doutOe && !aoutOe && !doutOut);
endmodule

bind slep_programmer slep_programmer_assertions #(.ENTRY_CYCLES(ENTRY_CYCLES))
    slep_programmer_assertions_i (.core_clk(core_clk), .resetn(resetn),
    .supAboveTen(supAboveTen), .cfgRdAddr(cfgRdAddr), .cfgRdData(cfgRdData),
    .progMode(progMode), .aoutOut(aoutOut), .aoutOe(aoutOe), .doutOut(doutOut),
    .doutOe(doutOe));

// [test/slep_programmer_tb_top.sv]
/*
 Self-checking bench of the programmer: write, bad checksum, read-out,
 refused commands and converter read-back. Assumes the station model.
*/
`timescale 1ns/10ps
`include "slep_cfg.svh"

module slep_programmer_tb_top;
    import slep_pkg::*;
    localparam int ENTRY = 20;
    logic core_clk = 0;
    logic resetn = 0;
    logic aoutSense = 0;
    logic refreshTick = 0;
    logic supAboveTen, supOneLevel, supProgLevel, supZeroLevel;
    logic [12:0] adcResult1 = 0;
    logic [12:0] adcResult2 = 0;
    logic [9:0] adcResult10 = 0;
    logic [3:0] cfgRdAddr = 0;
    logic [15:0] cfgRdData;
    logic progMode, aoutOut, aoutOe, doutOut, doutOe;
    logic [15:0] words [16];
    logic [35:0] adcBits;
    logic [19:0] sumExp;
    logic b;
    int n_mismatch = 0;
    int samples_checked = 0;
    int seed = 44752;
    int cycles = 0;

    always #2.5 core_clk = ~core_clk;

    slep_programmer #(.ENTRY_CYCLES(ENTRY)) slep_programmer_i (.core_clk(core_clk),
        .resetn(resetn), .supAboveTen(supAboveTen), .supOneLevel(supOneLevel),
        .supProgLevel(supProgLevel), .supZeroLevel(supZeroLevel), .aoutSense(aoutSense),
        .refreshTick(refreshTick), .adcResult1(adcResult1), .adcResult2(adcResult2),
        .adcResult10(adcResult10), .cfgRdAddr(cfgRdAddr), .cfgRdData(cfgRdData),
        .progMode(progMode), .aoutOut(aoutOut), .aoutOe(aoutOe), .doutOut(doutOut),
        .doutOe(doutOe));
    slep_station slep_station_i (.core_clk(core_clk), .supAboveTen(supAboveTen),
        .supOneLevel(supOneLevel), .supProgLevel(supProgLevel),
        .supZeroLevel(supZeroLevel));

    // ----------------
    // checking and closing
    // ----------------
    task automatic chk(logic [19:0] got, logic [19:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_mismatch++;
            results();
        end
    end

    function automatic logic [19:0] csum();
        logic [19:0] s;
        s = 20'h00000;
        for (int i = 0; i < 16; i++)
            s = s + {4'h0, words[i]};
        return s;
    endfunction

    task automatic tx(logic [19:0] v, int n, bit msb);
        for (int i = 0; i < n; i++)
            slep_station_i.sym(msb ? v[n - 1 - i] : v[i]);
    endtask

    // start delay before clocking kept short in place of milliseconds
    task automatic session(logic [11:0] cmd, logic cs);
        aoutSense = cs;
        slep_station_i.hold(LVL_OFF, 4);
        slep_station_i.hold(LVL_PROG, ENTRY + 8);
        chk(progMode, 1'h1);
        tx(cmd, 12, 1);
    endtask

    task automatic arrayCheck();
        slep_station_i.hold(LVL_OFF, 6);
        for (int i = 0; i < 16; i++)
        begin
            cfgRdAddr = i[3:0];
            repeat (2) @(posedge core_clk);
            #1;
            chk(cfgRdData, words[i]);
        end
    endtask

    task automatic payload(logic [15:0] delta, logic [19:0] sum);
        for (int i = 0; i < 16; i++)
            tx(words[i] + delta, 16, 0);
        tx(sum, 20, 0);
        slep_station_i.hold(LVL_PROG, 30);
    endtask

    initial
    begin
        for (int i = 0; i < 16; i++)
            words[i] = $random(seed);
        repeat (5) @(posedge core_clk);
        #1;
        resetn = 1;
        chk({progMode, aoutOe, doutOe}, 3'h0);
        slep_station_i.hold(LVL_PROG, ENTRY - 8);
        slep_station_i.hold(LVL_OFF, 6);
        chk(progMode, 1'h0);
        session(`SLEP_CMD_WR_BOTH | `SLEP_CS_MASK, 1'b1);
        payload(16'h0000, csum());
        chk({aoutOe, aoutOut, doutOe, doutOut}, 4'hF);
        arrayCheck();
        session(`SLEP_CMD_WR_DOUT, 1'b0);
        payload(16'h0001, csum());
        chk({aoutOe, doutOe, doutOut}, 3'h2);
        arrayCheck();
        session(`SLEP_CMD_READ | `SLEP_CS_MASK, 1'b0);
        slep_station_i.hold(LVL_PROG, 30);
        chk(doutOe, 1'h0);
        tx(`SLEP_CMD_READ, 12, 1);
        slep_station_i.hold(LVL_PROG, 30);
        chk({aoutOe, aoutOut, doutOe, doutOut}, 4'hF);
        sumExp = csum();
        for (int k = 0; k < 277; k++)
        begin
            slep_station_i.sym($random(seed));
            b = (k < 256) ? words[k / 16][k % 16] : (k < 276) ? sumExp[k - 256] : 1'b0;
            chk({aoutOut, doutOut}, {2{b}});
        end
        adcResult1 = $random(seed);
        adcResult2 = $random(seed);
        adcResult10 = $random(seed);
        adcBits = {adcResult10, adcResult2, adcResult1};
        session(`SLEP_CMD_ADC, 1'b0);
        tx(`SLEP_CMD_UNLOCK, 12, 1);
        tx(`SLEP_CMD_ADC, 12, 1);
        slep_station_i.hold(LVL_OFF, 10);
        repeat (21)
        begin
            refreshTick = 1;
            @(posedge core_clk);
            #1;
            refreshTick = 0;
            repeat (3) @(posedge core_clk);
            #1;
        end
        slep_station_i.hold(LVL_PROG, 10);
        chk({aoutOe, aoutOut, doutOe, doutOut}, 4'hF);
        for (int k = 0; k < 37; k++)
        begin
            slep_station_i.sym($random(seed));
            chk({aoutOe, aoutOut, doutOe, doutOut},
                (k < 36) ? {1'b1, adcBits[k], 1'b1, adcBits[k]} : 4'h0);
        end
        results();
    end
endmodule
